// File: core/usbn_pkg.sv
// usbn_pkg: constants, types and register map of the usb node logic
// assumes a 20 MHz system clock and byte-wide pipe traffic
package usbn_pkg;
  localparam int NPIPE      = 7;
  localparam int CTRL_DEPTH = 8;
  localparam int BIG_DEPTH  = 64;
  localparam int PTR_W      = 6;
  localparam int CNT_W      = 7;
  localparam int EPN_W      = 4;
  localparam int FADDR_W    = 7;
  localparam int EPC_W      = 6;

  localparam int CLK_HZ        = 20_000_000;
  localparam int IDLE_SUSP_US  = 3000;
  localparam int IDLE_SUSP_CYC = IDLE_SUSP_US * (CLK_HZ / 1_000_000);
  localparam int RESET_SE0_NS  = 2500;
  localparam int RESET_SE0_CYC = (RESET_SE0_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  localparam logic [7:0] OFS_STATE  = 8'h00;
  localparam logic [7:0] OFS_ALTERNATE_EVENT_REG  = 8'h04;
  localparam logic [7:0] OFS_ALTMSK = 8'h08;
  localparam logic [7:0] OFS_FADDR  = 8'h0C;
  localparam logic [7:0] OFS_EPC    = 8'h10;
  localparam logic [7:0] OFS_FIFO   = 8'h40;
  localparam logic [7:0] OFS_FCNT   = 8'h60;

  localparam int EV_RESET  = 0;
  localparam int EV_RESUME = 1;
  localparam int EV_IDLE   = 2;
  localparam int EV_W      = 3;
  localparam int EPC_EN    = 4;
  localparam int EPC_ISO   = 5;

  localparam logic [FADDR_W-1:0] DEF_FADDR = 7'h00;
  localparam logic [1:0]         RESP_OKAY = 2'h0;
  localparam logic [1:0]         RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {NODE_ACTIVE, NODE_SLEEP, NODE_WAKE, NODE_REINIT} usbn_state_t;

  typedef struct packed {
    logic se0;
    logic j;
    logic k;
  } usbn_line_t;

  typedef struct packed {
    logic               valid;
    logic               isIn;
    logic [FADDR_W-1:0] addr;
    logic [EPN_W-1:0]   endp;
  } usbn_tok_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } usbn_byte_t;
endpackage

// File: core/usbn_node.sv
// usbn_node: node state, line events, address/endpoint decode, seven pipes
// assumes line, token and byte inputs are decoded by a sie, synchronous to mclk
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module usbn_node
  import usbn_pkg::*;
#(
  parameter int IDLE_CYC = IDLE_SUSP_CYC
) (
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire usbn_pkg::usbn_line_t line,
  input  wire usbn_pkg::usbn_tok_t  tok,
  input  wire usbn_pkg::usbn_byte_t rxByte,
  input  wire logic                 txPop,
  output logic [7:0]                txData,
  output logic                      tokMatch,
  output logic [2:0]                tokPipe,
  output logic                      driveK,
  output logic                      wakeOut,
  output logic                      nodeIrq
);
  import usbn_pkg::*;

  usbn_state_t        state;
  logic [EV_W-1:0]    altEvent;
  logic [EV_W-1:0]    altMask;
  logic [FADDR_W-1:0] funcAddr;
  logic [EPC_W-1:0]   epc [NPIPE];
  logic [7:0]         fifoHead [NPIPE];
  logic [CNT_W-1:0]   fifoCnt [NPIPE];
  logic [NPIPE-1:0]   swPush;
  logic [NPIPE-1:0]   swPop;
  logic [NPIPE-1:0]   hit;
  logic               curValid;
  logic [31:0]        idleCnt;
  logic [31:0]        se0Cnt;
  logic               prevIdle;
  logic               resetEvt;
  logic               resumeEvt;
  logic               idleEvt;
  logic               wrFire;
  logic               rdFire;
  logic [7:0]         wrAddr;
  logic [31:0]        wrData;
  logic [31:0]        rdMux;
  logic               rdErr;
  logic               wrErr;
  logic               next_match;
  logic [2:0]         next_pipe;

  // returns {hit, index} for a block of NPIPE word registers
  function automatic logic [3:0] regIdx(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    if (a >= base && d < 8'(4 * NPIPE) && a[1:0] == 2'h0)
      return {1'b1, d[4:2]};
    return 4'h0;
  endfunction

  // axi write: address and data held until both present
  assign wrFire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      wrAddr        <= 8'h00;
      wrData        <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wrAddr        <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wrData       <= s_axi_wdata;
      end
      if (wrFire) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wrErr ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // write decode
  always_comb begin
    logic [3:0] e;
    logic [3:0] f;
    e = regIdx(wrAddr, OFS_EPC);
    f = regIdx(wrAddr, OFS_FIFO);
    swPush = '0;
    wrErr  = !(wrAddr == OFS_STATE || wrAddr == OFS_ALTERNATE_EVENT_REG || wrAddr == OFS_ALTMSK
               || wrAddr == OFS_FADDR || e[3] || f[3]);
    if (wrFire && f[3])
      swPush[f[2:0]] = 1'b1;
  end

  // axi read: one-cycle answer after address taken
  assign rdFire = s_axi_arvalid && s_axi_arready;
  always_comb begin
    logic [3:0] e;
    logic [3:0] f;
    logic [3:0] c;
    e = regIdx(s_axi_araddr, OFS_EPC);
    f = regIdx(s_axi_araddr, OFS_FIFO);
    c = regIdx(s_axi_araddr, OFS_FCNT);
    rdMux = 32'h0000_0000;
    rdErr = 1'b0;
    swPop = '0;
    if (s_axi_araddr == OFS_STATE)
      rdMux[1:0] = state;
    else if (s_axi_araddr == OFS_ALTERNATE_EVENT_REG)
      rdMux[EV_W-1:0] = altEvent;
    else if (s_axi_araddr == OFS_ALTMSK)
      rdMux[EV_W-1:0] = altMask;
    else if (s_axi_araddr == OFS_FADDR)
      rdMux[FADDR_W-1:0] = funcAddr;
    else if (e[3])
      rdMux[EPC_W-1:0] = epc[e[2:0]];
    else if (f[3]) begin
      rdMux[7:0] = fifoHead[f[2:0]];
      swPop[f[2:0]] = rdFire;
    end else if (c[3])
      rdMux[CNT_W-1:0] = fifoCnt[c[2:0]];
    else
      rdErr = 1'b1;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (rdFire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rdMux;
      s_axi_rresp   <= rdErr ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // line condition detectors
  assign idleEvt   = line.j && idleCnt == 32'(IDLE_CYC - 1);
  assign resetEvt  = line.se0 && se0Cnt == 32'(RESET_SE0_CYC - 1);
  assign resumeEvt = state == NODE_SLEEP && line.k && prevIdle;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      idleCnt  <= 32'h0000_0000;
      se0Cnt   <= 32'h0000_0000;
      prevIdle <= 1'b0;
    end else begin
      prevIdle <= line.j;
      if (!line.j)
        idleCnt <= 32'h0000_0000;
      else if (idleCnt < 32'(IDLE_CYC))
        idleCnt <= idleCnt + 32'h0000_0001;
      if (!line.se0)
        se0Cnt <= 32'h0000_0000;
      else if (se0Cnt < 32'(RESET_SE0_CYC))
        se0Cnt <= se0Cnt + 32'h0000_0001;
    end
  end

  // alternate events: set beats write-one-to-clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      altEvent <= '0;
      altMask  <= '0;
      nodeIrq  <= 1'b0;
    end else begin
      altEvent <= (altEvent & ~((wrFire && wrAddr == OFS_ALTERNATE_EVENT_REG) ? wrData[EV_W-1:0] : '0))
                  | {idleEvt, resumeEvt, resetEvt};
      if (wrFire && wrAddr == OFS_ALTMSK)
        altMask <= wrData[EV_W-1:0];
      nodeIrq <= |(altEvent & altMask);
    end
  end

  // node state
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state   <= NODE_REINIT;
      driveK  <= 1'b0;
      wakeOut <= 1'b0;
    end else begin
      if (resetEvt)
        state <= NODE_REINIT;
      else if (wrFire && wrAddr == OFS_STATE)
        state <= usbn_state_t'(wrData[1:0]);
      driveK  <= state == NODE_WAKE;
      wakeOut <= state == NODE_SLEEP && prevIdle && !line.j;
    end
  end

  // function address and endpoint control
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      funcAddr <= DEF_FADDR;
    end else if (resetEvt) begin
      funcAddr <= DEF_FADDR;
    end else if (wrFire && wrAddr == OFS_FADDR) begin
      funcAddr <= wrData[FADDR_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NPIPE; i++)
        epc[i] <= '0;
    end else begin
      for (int i = 0; i < NPIPE; i++)
        if (wrFire && regIdx(wrAddr, OFS_EPC) == {1'b1, 3'(i)})
          epc[i] <= wrData[EPC_W-1:0];
    end
  end

  // pipes and their fifos
  for (genvar p = 0; p < NPIPE; p++) begin : g_pipe
    localparam int  DEPTH  = (p == 0) ? CTRL_DEPTH : BIG_DEPTH;
    localparam bit  CAN_TX = (p == 0) || (p % 2 == 1);
    localparam bit  CAN_RX = (p % 2 == 0);
    logic [7:0]       mem [BIG_DEPTH];
    logic [PTR_W-1:0] rp;
    logic [PTR_W-1:0] wp;
    logic             linkPush;
    logic             push;
    logic             pop;
    logic             dirOk;
    logic             isoBlock;

    assign linkPush = CAN_RX && rxByte.valid && curValid && tokPipe == 3'(p);
    assign push = (linkPush || (CAN_TX && swPush[p])) && fifoCnt[p] < CNT_W'(DEPTH);
    assign pop  = ((CAN_TX && txPop && curValid && tokPipe == 3'(p)) || (CAN_RX && swPop[p]))
                  && fifoCnt[p] != '0;
    assign fifoHead[p] = mem[rp];
    assign dirOk = (p == 0) || (tok.isIn ? CAN_TX : CAN_RX);
    assign isoBlock = epc[p][EPC_ISO] && (tok.isIn ? fifoCnt[p] == '0 : fifoCnt[p] == CNT_W'(DEPTH));
    assign hit[p] = epc[p][EPC_EN] && epc[p][EPN_W-1:0] == tok.endp && dirOk && !isoBlock;

    always_ff @(posedge mclk) begin
      if (push)
        mem[wp] <= linkPush ? rxByte.data : wrData[7:0];
    end

    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        rp         <= '0;
        wp         <= '0;
        fifoCnt[p] <= '0;
      end else begin
        if (push)
          wp <= (wp == PTR_W'(DEPTH - 1)) ? '0 : wp + PTR_W'(1);
        if (pop)
          rp <= (rp == PTR_W'(DEPTH - 1)) ? '0 : rp + PTR_W'(1);
        if (push && !pop)
          fifoCnt[p] <= fifoCnt[p] + CNT_W'(1);
        else if (pop && !push)
          fifoCnt[p] <= fifoCnt[p] - CNT_W'(1);
      end
    end
  end

  // lowest-numbered matching pipe wins
  always_comb begin
    next_match = 1'b0;
    next_pipe  = 3'h0;
    for (int i = NPIPE - 1; i >= 0; i--)
      if (hit[i]) begin
        next_match = 1'b1;
        next_pipe  = 3'(i);
      end
    if (tok.addr != funcAddr || !(state == NODE_ACTIVE || state == NODE_REINIT))
      next_match = 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      curValid <= 1'b0;
      tokMatch <= 1'b0;
      tokPipe  <= 3'h0;
      txData   <= 8'h00;
    end else begin
      tokMatch <= tok.valid && next_match;
      if (tok.valid) begin
        curValid <= next_match;
        tokPipe  <= next_pipe;
      end
      if (txPop && curValid)
        txData <= fifoHead[tokPipe];
    end
  end

  a_drive_k: assert property (@(posedge mclk) disable iff (!rst_b)
    $past(state) == NODE_WAKE |-> driveK) else $error("K not driven in wake state");
  a_wake_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
    wakeOut |-> $past(state) == NODE_SLEEP && $past(prevIdle)) else $error("wake pulse without idle sleep");
  a_reset_flag: assert property (@(posedge mclk) disable iff (!rst_b)
    resetEvt |=> altEvent[EV_RESET]) else $error("reset event not recorded");
  a_reset_addr: assert property (@(posedge mclk) disable iff (!rst_b)
    resetEvt |=> funcAddr == DEF_FADDR && state == NODE_REINIT) else $error("reset did not restore default");
  a_idle_flag: assert property (@(posedge mclk) disable iff (!rst_b)
    idleEvt |=> altEvent[EV_IDLE]) else $error("idle flag not set");
  a_irq_gate: assert property (@(posedge mclk) disable iff (!rst_b)
    nodeIrq |-> $past(|(altEvent & altMask))) else $error("interrupt without enabled event");
  a_match_addr: assert property (@(posedge mclk) disable iff (!rst_b)
    tokMatch |-> $past(tok.addr == funcAddr && tok.valid)) else $error("match on foreign address");
  a_match_low: assert property (@(posedge mclk) disable iff (!rst_b)
    tokMatch |-> (($past(hit) >> tokPipe) & 7'h01) == 7'h01
      && ($past(hit) & ((7'h01 << tokPipe) - 7'h01)) == 7'h00)
    else $error("match not on lowest pipe");
endmodule // usbn_node

// File: dv/usbn_host_model.sv
// usbn_host_model: host controller side of the usb link
// assumes mclk from the bench; every change lands just after a rising edge
`timescale 1ns/1ps
module usbn_host_model (
  input  wire logic            mclk,
  output usbn_pkg::usbn_line_t line,
  output usbn_pkg::usbn_tok_t  tok,
  output usbn_pkg::usbn_byte_t rxByte,
  output logic                 txPop
);
  import usbn_pkg::*;

  initial begin
    line = 3'b010;
    tok = '0;
    rxByte = '0;
    txPop = 1'b0;
  end

  task automatic set_line(input usbn_line_t c);
    @(posedge mclk);
    line <= c;
  endtask

  // released fields show inverted values, not the last ones
  task automatic send_tok(input logic isIn, input logic [6:0] a, input logic [3:0] e);
    @(posedge mclk);
    tok <= {1'b1, isIn, a, e};
    @(posedge mclk);
    tok <= {1'b0, ~isIn, ~a, ~e};
  endtask

  // gap lets the host answer promptly or slowly
  task automatic send_byte(input logic [7:0] d, input int gap);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    rxByte <= {1'b1, d};
    @(posedge mclk);
    rxByte <= {1'b0, ~d};
  endtask

  task automatic pop;
    @(posedge mclk);
    txPop <= 1'b1;
    @(posedge mclk);
    txPop <= 1'b0;
  endtask

  // host keeps resume signalling, then closes with end-of-packet
  task automatic end_resume(input int n);
    @(posedge mclk);
    line <= 3'b001;
    repeat (n) @(posedge mclk);
    line <= 3'b100;
    repeat (2) @(posedge mclk);
    line <= 3'b010;
  endtask
endmodule // usbn_host_model

// File: dv/testbench.sv
// testbench: drives usbn_node over axi4-lite and through the host model
// assumes usbn_pkg and usbn_host_model are compiled before it
`timescale 1ns/1ps
module testbench;
  import usbn_pkg::*;
  localparam int IDLE = 20;
  logic        mclk, rst_b, txPop, tokMatch, driveK, wakeOut, nodeIrq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, txData;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, ep;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [2:0]  tokPipe;
  logic [6:0]  fa;
  usbn_line_t  line;
  usbn_tok_t   tok;
  usbn_byte_t  rxByte;
  logic [3:0]  epN [7];
  logic        epE [7] = '{default: 1'b0};
  logic [7:0]  q [$];
  int          n_errors = 0;
  int          cmp_count = 0;
  int          w;

  usbn_node #(.IDLE_CYC(IDLE)) usbn_node_inst (.mclk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line, .tok, .rxByte, .txPop, .txData,
    .tokMatch, .tokPipe, .driveK, .wakeOut, .nodeIrq);
  usbn_host_model hostModel (.mclk, .line, .tok, .rxByte, .txPop);

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic summarize;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    summarize();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'($urandom_range(15, 1));
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask

  // lowest enabled pipe of the token's direction, 7 when none
  function automatic int expPipe(input logic isIn, input logic [3:0] e);
    for (int n = 0; n < 7; n++)
      if (epE[n] && epN[n] == e && (n == 0 || n[0] == isIn)) return n;
    return 7;
  endfunction

  task automatic setEp(input int n, input logic [3:0] e, input logic en);
    epN[n] = e;
    epE[n] = en;
    axw(OFS_EPC + 8'(4 * n), {26'h0, 1'b0, en, e});
  endtask

  task automatic tokChk(input logic isIn, input logic [6:0] a, input logic [3:0] e, input int exp);
    hostModel.send_tok(isIn, a, e);
    #1;
    chk(tokMatch, exp != 7);
    if (exp != 7) chk(tokPipe, exp);
  endtask

  initial begin
    void'($urandom(32'h93be));
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    rst_b = 1'b0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    axr(OFS_STATE);
    chk(rd, 32'h3);
    axr(OFS_FADDR);
    chk(rd, 32'h0);
    axr(8'hfc);
    chk(rsp, RESP_SLVERR);
    axw(8'hfc, 32'h1);
    chk(rsp, RESP_SLVERR);
    axw(OFS_ALTMSK, 32'h0);
    chk(rsp, RESP_OKAY);
    axr(OFS_ALTMSK);
    chk(rsp, RESP_OKAY);
    chk(rd, 32'h0);
    setEp(0, 4'h0, 1'b1);
    tokChk(1'b0, DEF_FADDR, 4'h0, 0);
    tokChk(1'b0, 7'h01, 4'h0, 7);
    setEp(0, 4'h0, 1'b0);
    fa = 7'($urandom_range(127, 1));
    ep = 4'($urandom_range(15, 1));
    axw(OFS_FADDR, 32'(fa));
    axw(OFS_STATE, 32'h0);
    for (int n = 1; n < 7; n++) setEp(n, 4'(n), 1'b1);
    for (int n = 1; n < 7; n++) tokChk(n[0], fa, 4'(n), expPipe(n[0], 4'(n)));
    for (int n = 1; n < 5; n++) setEp(n, ep, 1'b1);
    tokChk(1'b0, fa ^ 7'h01, ep, 7);
    tokChk(1'b1, fa, ep, expPipe(1'b1, ep));
    tokChk(1'b0, fa, ep, expPipe(1'b0, ep));
    for (int i = 0; i < 70; i++) begin
      q.push_back(8'($urandom));
      hostModel.send_byte(q[i], i % 3);
    end
    axr(OFS_FCNT + 8'h08);
    chk(rd, BIG_DEPTH);
    for (int i = 0; i < 3; i++) begin
      axr(OFS_FIFO + 8'h08);
      chk(rd[7:0], q[i]);
    end
    setEp(2, ep, 1'b0);
    tokChk(1'b0, fa, ep, expPipe(1'b0, ep));
    for (int i = 0; i < 3; i++) axw(OFS_FIFO + 8'h04, 32'(q[i]));
    tokChk(1'b1, fa, ep, 1);
    for (int i = 0; i < 3; i++) begin
      hostModel.pop();
      #1;
      chk(txData, q[i]);
    end
    axw(OFS_EPC + 8'h04, {26'h0, 1'b1, 1'b1, ep});
    tokChk(1'b1, fa, ep, 3);
    axw(OFS_FIFO + 8'h04, 32'(q[3]));
    tokChk(1'b1, fa, ep, 1);
    for (int i = 0; i < 9; i++) axw(OFS_FIFO, 32'(i));
    axr(OFS_FCNT);
    chk(rd, CTRL_DEPTH);
    axw(OFS_ALTMSK, 32'h7);
    hostModel.set_line(3'b001);
    hostModel.set_line(3'b010);
    axw(OFS_ALTERNATE_EVENT_REG, 32'h7);
    axr(OFS_ALTERNATE_EVENT_REG);
    chk(rd[EV_IDLE], 1'b0);
    repeat (IDLE) @(posedge mclk);
    axr(OFS_ALTERNATE_EVENT_REG);
    chk(rd[EV_IDLE], 1'b1);
    chk(nodeIrq, 1'b1);
    axw(OFS_ALTMSK, 32'h0);
    repeat (2) @(posedge mclk);
    chk(nodeIrq, 1'b0);
    axw(OFS_ALTMSK, 32'h7);
    axw(OFS_STATE, 32'h1);
    tokChk(1'b0, fa, ep, 7);
    axw(OFS_ALTERNATE_EVENT_REG, 32'h7);
    hostModel.set_line(3'b001);
    w = 0;
    repeat (4) begin
      @(posedge mclk);
      #1 w += int'(wakeOut);
    end
    chk(w, 1);
    axr(OFS_ALTERNATE_EVENT_REG);
    chk(rd[EV_RESUME], 1'b1);
    chk(nodeIrq, 1'b1);
    hostModel.set_line(3'b010);
    axw(OFS_STATE, 32'h2);
    @(posedge mclk);
    #1 chk(driveK, 1'b1);
    axw(OFS_STATE, 32'h2);
    #1 chk(driveK, 1'b1);
    axw(OFS_STATE, 32'h0);
    repeat (2) @(posedge mclk);
    chk(driveK, 1'b0);
    hostModel.end_resume(IDLE);
    tokChk(1'b0, fa, ep, expPipe(1'b0, ep));
    hostModel.set_line(3'b100);
    repeat (55) @(posedge mclk);
    hostModel.set_line(3'b010);
    axr(OFS_ALTERNATE_EVENT_REG);
    chk(rd[EV_RESET], 1'b1);
    axr(OFS_STATE);
    chk(rd, 32'h3);
    axr(OFS_FADDR);
    chk(rd, 32'h0);
    tokChk(1'b0, fa, ep, 7);
    summarize();
  end
endmodule // testbench
